//--- design/rsa_addr_gen.sv
// Operation
// RULE_01 - Long relative: pc plus signed 16-bit offset
// RULE_02 - Long branch loads pc; push-relative pushes sum
// RULE_03 - Relative modes never touch program bank
// RULE_04 - Short branch adds signed offset when taken
// RULE_05 - Stack accesses always go to bank zero
// RULE_06 - Interrupt vectors fetched from bank zero
// RULE_07 - Stack relative: byte2 plus sp, bank zero
// RULE_08 - Stack relative offset is zero-extended
// RULE_09 - Stack indirect pointer in bank zero, data bank
// RULE_10 - Indirect indexed: full 24-bit add of Y
// RULE_11 - Stack indirect indexed: 2 bytes, 7 cycles
// RULE_12 - Page crossing adds one cycle
// RULE_13 - Taken branch adds one cycle
// RULE_14 - 16-bit width adds cycle, immediate byte
// RULE_15 - Nonzero direct low byte adds cycle
// RULE_16 - Read-modify-write adds two or three cycles
// RULE_17 - Direct indexed indirect: 2 bytes, 6 cycles
// RULE_18 - Direct indirect indexed Y: 2 bytes, 5 cycles
// RULE_19 - Long direct indirect indexed: 2 bytes, 6 cycles
// RULE_20 - Absolute indexed indirect jump: 3 bytes, 6 cycles
// RULE_21 - All applicable adders sum onto base count
`timescale 1ns/100ps
`default_nettype none
module rsa_addr_gen
  import rsa_pkg::*;
(
  input  wire logic           sys_clk,     // Processor clock, 10 MHz
  input  wire logic           srst,        // Synchronous reset, active high
  input  wire logic           start,       // Pulse: decoded instruction valid
  input  wire rsa_pkg::rsa_instr_type instr, // Decoded instruction fields
  input  wire rsa_pkg::rsa_regs_type  regs,  // Register file snapshot
  input  wire logic           ptr_valid,   // Pulse: pointer read data returned
  input  wire logic [15:0]    ptr_data,    // 16-bit pointer read from memory
  output logic                ptr_req,     // Level: pointer read pending
  output logic [23:0]         ptr_addr,    // Address of pointer read
  output logic                done,        // Pulse: result valid
  output rsa_pkg::rsa_result_type result   // Registered result
);
  import rsa_pkg::*;

  typedef enum logic [0:0] {
    RSA_ST_IDLE = 1'b0,
    RSA_ST_PTR  = 1'b1
  } rsa_state_type;

  rsa_state_type  state_reg;
  rsa_state_type  state_next;
  rsa_result_type result_reg;
  rsa_result_type result_next;
  logic [23:0]    ptr_addr_reg;
  logic [23:0]    ptr_addr_next;
  logic           done_reg;
  logic           done_next;
  logic [7:0]     pend_y_bank_reg;
  logic [15:0]    pend_y_reg;
  logic [3:0]     pend_cyc_reg;
  logic [2:0]     pend_len_reg;

  // Shared page-cross detector for indexed forms
  function automatic logic page_cross(input logic [15:0] base, input logic [15:0] idx);
    logic [16:0] sum;
    sum = {1'b0, base} + {1'b0, idx};
    page_cross = (sum[15:8] != base[15:8]) || sum[16];
  endfunction

  // Full 24-bit add of a 16-bit index, carrying into the bank
  function automatic logic [23:0] add_index24(input logic [23:0] base, input logic [15:0] idx);
    add_index24 = base + {8'h00, idx};
  endfunction

  wire logic        wide_op    = ~regs.m_flag | ~regs.x_flag;
  wire logic        dl_nonzero = regs.direct[7:0] != 8'h00;
  wire logic [15:0] off8_sext  = {{8{instr.byte2[7]}}, instr.byte2};
  wire logic [15:0] off16      = {instr.byte3, instr.byte2};
  wire logic [15:0] off8_zext  = {8'h00, instr.byte2};                 // RULE_08
  wire logic [15:0] rel_sum    = regs.pc_next + off8_sext;             // RULE_04
  wire logic [15:0] rel_long   = regs.pc_next + off16;                 // RULE_01
  wire logic [15:0] sp_offset  = regs.sp + off8_zext;                  // RULE_07
  wire logic [15:0] abs_base   = off16;
  wire logic [15:0] dir_base   = regs.direct + off8_zext;

  // Base cycles and length by mode
  logic [3:0]  base_cyc;
  logic [2:0]  base_len;
  logic        uses_pcross;
  logic [15:0] pcross_idx;
  logic        uses_dl;
  always_comb
  begin
    base_cyc    = RSA_CYC_TWO;
    base_len    = RSA_LEN_1;
    uses_pcross = 1'b0;
    pcross_idx  = regs.x_idx;
    uses_dl     = 1'b0;
    unique case (instr.mode)
      RSA_MODE_REL:      begin base_cyc = RSA_CYC_REL;      base_len = RSA_LEN_2; end
      RSA_MODE_REL_LONG: begin base_cyc = RSA_CYC_REL_LONG; base_len = RSA_LEN_3; end
      RSA_MODE_STACK:    begin base_cyc = RSA_CYC_STACK;    base_len = RSA_LEN_1; end
      RSA_MODE_STK_REL:  begin base_cyc = RSA_CYC_STK_REL;  base_len = RSA_LEN_2; end
      RSA_MODE_STK_RIY:  begin base_cyc = RSA_CYC_STK_RIY;  base_len = RSA_LEN_2; end // RULE_11
      RSA_MODE_ABS:      begin base_cyc = RSA_CYC_ABS;      base_len = RSA_LEN_3; end
      RSA_MODE_ABS_IIJ:  begin base_cyc = RSA_CYC_ABS_IIJ;  base_len = RSA_LEN_3; end // RULE_20
      RSA_MODE_ABS_IND:  begin base_cyc = RSA_CYC_ABS_IND;  base_len = RSA_LEN_3; end
      RSA_MODE_ABS_LONG: begin base_cyc = RSA_CYC_ABS_LONG; base_len = RSA_LEN_4; end
      RSA_MODE_ABS_LX:   begin base_cyc = RSA_CYC_ABS_LONG; base_len = RSA_LEN_4; end
      RSA_MODE_ABS_X:
      begin
        base_cyc    = RSA_CYC_ABS;
        base_len    = RSA_LEN_3;
        uses_pcross = 1'b1;                                              // RULE_12
      end
      RSA_MODE_ABS_Y:
      begin
        base_cyc    = RSA_CYC_ABS;
        base_len    = RSA_LEN_3;
        uses_pcross = 1'b1;                                              // RULE_12
        pcross_idx  = regs.y_idx;
      end
      RSA_MODE_ACC:      begin base_cyc = RSA_CYC_TWO;      base_len = RSA_LEN_1; end
      RSA_MODE_BLK_MOVE: begin base_cyc = RSA_CYC_BLK_MOVE; base_len = RSA_LEN_3; end
      RSA_MODE_DIR:
      begin
        base_cyc = RSA_CYC_DIR;
        base_len = RSA_LEN_2;
        uses_dl  = 1'b1;
      end
      RSA_MODE_DIR_XI:
      begin
        base_cyc = RSA_CYC_DIR_XI;                                       // RULE_17
        base_len = RSA_LEN_2;
        uses_dl  = 1'b1;
      end
      RSA_MODE_DIR_IND:
      begin
        base_cyc = RSA_CYC_DIR_IND;
        base_len = RSA_LEN_2;
        uses_dl  = 1'b1;
      end
      RSA_MODE_DIR_IY:
      begin
        base_cyc    = RSA_CYC_DIR_IY;                                    // RULE_18
        base_len    = RSA_LEN_2;
        uses_dl     = 1'b1;
        uses_pcross = 1'b1;
        pcross_idx  = regs.y_idx;
      end
      RSA_MODE_DIR_LIY:
      begin
        base_cyc = RSA_CYC_DIR_LONG;                                     // RULE_19
        base_len = RSA_LEN_2;
        uses_dl  = 1'b1;
      end
      RSA_MODE_DIR_LI:
      begin
        base_cyc = RSA_CYC_DIR_LONG;
        base_len = RSA_LEN_2;
        uses_dl  = 1'b1;
      end
      RSA_MODE_DIR_X, RSA_MODE_DIR_Y:
      begin
        base_cyc = RSA_CYC_DIR_IDX;
        base_len = RSA_LEN_2;
        uses_dl  = 1'b1;
      end
      RSA_MODE_IMM:      begin base_cyc = RSA_CYC_TWO;      base_len = RSA_LEN_2; end
      RSA_MODE_IMPLIED:  begin base_cyc = RSA_CYC_TWO;      base_len = RSA_LEN_1; end
      default:           begin base_cyc = RSA_CYC_TWO;      base_len = RSA_LEN_1; end
    endcase
  end

  // Adders; the absolute indexed indirect jump takes none
  wire logic is_branch = (instr.mode == RSA_MODE_REL) ||
                         (instr.mode == RSA_MODE_REL_LONG && instr.rl_op == RSA_RL_LONG_BRANCH);
  wire logic no_adders = instr.mode == RSA_MODE_ABS_IIJ;                          // RULE_20
  wire logic taken     = (instr.mode == RSA_MODE_REL) ? instr.cond_met : is_branch;
  wire logic [3:0] add_taken = (is_branch && taken) ? RSA_ONE_CYCLE : 4'h0;       // RULE_13
  wire logic [3:0] add_wide  = (!no_adders && instr.wide_sensitive && wide_op)
                               ? RSA_ONE_CYCLE : 4'h0;                            // RULE_14
  wire logic [3:0] add_dl    = (uses_dl && dl_nonzero) ? RSA_ONE_CYCLE : 4'h0;    // RULE_15
  wire logic [3:0] add_rmw   = (!no_adders && instr.rmw)
                               ? (regs.m_flag ? RSA_RMW_NARROW : RSA_RMW_WIDE)
                               : 4'h0;                                            // RULE_16
  wire logic [3:0] add_pc_abs = (uses_pcross && instr.mode != RSA_MODE_DIR_IY &&
                                 page_cross(abs_base, pcross_idx)) ? RSA_ONE_CYCLE : 4'h0;
  wire logic [2:0] add_imm   = (instr.mode == RSA_MODE_IMM && wide_op) ? RSA_ONE_BYTE : 3'h0;

  // Decode-time adders; the pointer page cross joins later
  wire logic [3:0] cyc_total = base_cyc + add_taken + add_wide + add_dl + add_rmw
                               + add_pc_abs;                                      // RULE_21
  wire logic [2:0] len_total = base_len + add_imm;                                // RULE_14

  // Indirect pointer lookups: stack relative or direct indirect with Y
  wire logic needs_ptr = (instr.mode == RSA_MODE_STK_RIY) || (instr.mode == RSA_MODE_DIR_IY);
  wire logic [15:0] ptr_lo = (instr.mode == RSA_MODE_STK_RIY) ? sp_offset : dir_base;

  // Address produced without a pointer read
  logic [23:0] direct_addr;
  logic        direct_addr_valid;
  always_comb
  begin
    direct_addr       = 24'h000000;
    direct_addr_valid = 1'b0;
    unique case (instr.mode)
      RSA_MODE_STACK:
      begin
        direct_addr       = {RSA_BANK_ZERO, regs.sp};                  // RULE_05 RULE_06
        direct_addr_valid = 1'b1;
      end
      RSA_MODE_STK_REL:
      begin
        direct_addr       = {RSA_BANK_ZERO, sp_offset};                // RULE_07
        direct_addr_valid = 1'b1;
      end
      RSA_MODE_REL_LONG:
      begin
        // Push-relative writes the sum onto the stack in bank zero
        direct_addr       = {RSA_BANK_ZERO, regs.sp};                  // RULE_05
        direct_addr_valid = instr.rl_op == RSA_RL_PUSH_RELATIVE;       // RULE_02
      end
      default:
      begin
        direct_addr       = 24'h000000;
        direct_addr_valid = 1'b0;
      end
    endcase
  end

  // Full address after pointer arrival, bank from data bank
  wire logic [23:0] ptr_base    = {pend_y_bank_reg, ptr_data};          // RULE_09
  wire logic [23:0] ptr_eff     = add_index24(ptr_base, pend_y_reg);    // RULE_10
  wire logic [3:0]  ptr_pc_add  = (pend_len_reg[2] && page_cross(ptr_data, pend_y_reg))
                                  ? RSA_ONE_CYCLE : 4'h0;               // RULE_12

  always_comb
  begin
    state_next    = state_reg;
    result_next   = result_reg;
    ptr_addr_next = ptr_addr_reg;
    done_next     = 1'b0;
    unique case (state_reg)
      RSA_ST_IDLE:
      begin
        if (start && needs_ptr)
        begin
          ptr_addr_next = {RSA_BANK_ZERO, ptr_lo};                      // RULE_09
          state_next    = RSA_ST_PTR;
        end
        else if (start)
        begin
          result_next.addr       = direct_addr;
          result_next.addr_valid = direct_addr_valid;
          // Only the 16-bit pc is loaded; program bank is never written
          result_next.pc_load    = (instr.mode == RSA_MODE_REL) ? rel_sum : rel_long; // RULE_03
          result_next.pc_load_en = (instr.mode == RSA_MODE_REL && instr.cond_met) ||
                                   (instr.mode == RSA_MODE_REL_LONG &&
                                    instr.rl_op == RSA_RL_LONG_BRANCH);               // RULE_02 RULE_04
          result_next.push_value = rel_long;                                          // RULE_01
          result_next.push_en    = instr.mode == RSA_MODE_REL_LONG &&
                                   instr.rl_op == RSA_RL_PUSH_RELATIVE;               // RULE_02
          result_next.cycles     = cyc_total;
          result_next.length     = len_total;
          done_next              = 1'b1;
        end
      end
      RSA_ST_PTR:
      begin
        if (ptr_valid)
        begin
          result_next.addr       = ptr_eff;
          result_next.addr_valid = 1'b1;
          result_next.pc_load    = 16'h0000;
          result_next.pc_load_en = 1'b0;
          result_next.push_value = 16'h0000;
          result_next.push_en    = 1'b0;
          result_next.cycles     = pend_cyc_reg + ptr_pc_add;           // RULE_21
          result_next.length     = RSA_LEN_2;                           // RULE_11
          done_next              = 1'b1;
          state_next             = RSA_ST_IDLE;
        end
      end
      default:
        state_next = RSA_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg    <= RSA_ST_IDLE;
      result_reg   <= '0;
      ptr_addr_reg <= 24'h000000;
      done_reg     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      result_reg   <= result_next;
      ptr_addr_reg <= ptr_addr_next;
      done_reg     <= done_next;
    end
  end

  // Held while the pointer read is out; length bit 2
  // flags the pointer page-cross check
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pend_y_bank_reg <= 8'h00;
      pend_y_reg      <= 16'h0000;
      pend_cyc_reg    <= 4'h0;
      pend_len_reg    <= 3'h0;
    end
    else if (state_reg == RSA_ST_IDLE && start && needs_ptr)
    begin
      pend_y_bank_reg <= regs.data_bank;
      pend_y_reg      <= regs.y_idx;
      pend_cyc_reg    <= cyc_total;
      pend_len_reg    <= {instr.mode == RSA_MODE_DIR_IY, 2'b00};
    end
  end

  assign ptr_req  = state_reg == RSA_ST_PTR;
  assign ptr_addr = ptr_addr_reg;
  assign done     = done_reg;
  assign result   = result_reg;

endmodule // rsa_addr_gen
`default_nettype wire

//--- shared/rsa_pkg.sv
`default_nettype none
package rsa_pkg;

  // Addressing modes handled by the generator
  typedef enum logic [4:0] {
    RSA_MODE_REL      = 5'h00,
    RSA_MODE_REL_LONG = 5'h01,
    RSA_MODE_STACK    = 5'h02,
    RSA_MODE_STK_REL  = 5'h03,
    RSA_MODE_STK_RIY  = 5'h04,
    RSA_MODE_ABS      = 5'h05,
    RSA_MODE_ABS_IIJ  = 5'h06,
    RSA_MODE_ABS_IND  = 5'h07,
    RSA_MODE_ABS_LONG = 5'h08,
    RSA_MODE_ABS_LX   = 5'h09,
    RSA_MODE_ABS_X    = 5'h0A,
    RSA_MODE_ABS_Y    = 5'h0B,
    RSA_MODE_ACC      = 5'h0C,
    RSA_MODE_BLK_MOVE = 5'h0D,
    RSA_MODE_DIR      = 5'h0E,
    RSA_MODE_DIR_XI   = 5'h0F,
    RSA_MODE_DIR_IND  = 5'h10,
    RSA_MODE_DIR_IY   = 5'h11,
    RSA_MODE_DIR_LIY  = 5'h12,
    RSA_MODE_DIR_LI   = 5'h13,
    RSA_MODE_DIR_X    = 5'h14,
    RSA_MODE_DIR_Y    = 5'h15,
    RSA_MODE_IMM      = 5'h16,
    RSA_MODE_IMPLIED  = 5'h17
  } rsa_mode_type;

  // Relative-long sub-operation
  typedef enum logic [1:0] {
    RSA_RL_NONE = 2'h0,
    RSA_RL_LONG_BRANCH = 2'h1,
    RSA_RL_PUSH_RELATIVE = 2'h2
  } rsa_rl_op_type;

  // One decoded instruction presented to the generator
  typedef struct packed {
    rsa_mode_type  mode;
    rsa_rl_op_type rl_op;          // long_branch_op / push_relative_op select
    logic          cond_met;       // Branch condition result
    logic          rmw;            // Read-modify-write instruction
    logic          wide_sensitive; // Mode carries the 16-bit adder
    logic          vector_fetch;   // Stack access is a vector fetch
    logic [7:0]    byte2;
    logic [7:0]    byte3;
    logic [7:0]    byte4;
  } rsa_instr_type;

  // Register file snapshot
  typedef struct packed {
    logic [15:0] pc_next;          // Already advanced to next opcode
    logic [7:0]  program_bank;
    logic [7:0]  data_bank;
    logic [15:0] direct;
    logic [15:0] sp;
    logic [15:0] x_idx;
    logic [15:0] y_idx;
    logic        m_flag;
    logic        x_flag;
  } rsa_regs_type;

  // Result of one generation step
  typedef struct packed {
    logic [23:0] addr;
    logic        addr_valid;
    logic [15:0] pc_load;
    logic        pc_load_en;
    logic [15:0] push_value;
    logic        push_en;
    logic [3:0]  cycles;
    logic [2:0]  length;
  } rsa_result_type;

  localparam logic [7:0]  RSA_BANK_ZERO = 8'h00;
  localparam logic [3:0]  RSA_ONE_CYCLE = 4'h1;
  localparam logic [3:0]  RSA_RMW_NARROW = 4'h2;
  localparam logic [3:0]  RSA_RMW_WIDE = 4'h3;
  localparam logic [2:0]  RSA_ONE_BYTE = 3'h1;

  // Base cycles per mode
  localparam logic [3:0] RSA_CYC_REL = 4'h2;
  localparam logic [3:0] RSA_CYC_REL_LONG = 4'h3;
  localparam logic [3:0] RSA_CYC_STACK = 4'h3;
  localparam logic [3:0] RSA_CYC_STK_REL = 4'h4;
  localparam logic [3:0] RSA_CYC_STK_RIY = 4'h7;
  localparam logic [3:0] RSA_CYC_ABS = 4'h4;
  localparam logic [3:0] RSA_CYC_ABS_IIJ = 4'h6;
  localparam logic [3:0] RSA_CYC_ABS_IND = 4'h5;
  localparam logic [3:0] RSA_CYC_ABS_LONG = 4'h5;
  localparam logic [3:0] RSA_CYC_TWO = 4'h2;
  localparam logic [3:0] RSA_CYC_BLK_MOVE = 4'h7;
  localparam logic [3:0] RSA_CYC_DIR = 4'h3;
  localparam logic [3:0] RSA_CYC_DIR_XI = 4'h6;
  localparam logic [3:0] RSA_CYC_DIR_IND = 4'h5;
  localparam logic [3:0] RSA_CYC_DIR_IY = 4'h5;
  localparam logic [3:0] RSA_CYC_DIR_LONG = 4'h6;
  localparam logic [3:0] RSA_CYC_DIR_IDX = 4'h4;

  // Instruction lengths in bytes
  localparam logic [2:0] RSA_LEN_1 = 3'h1;
  localparam logic [2:0] RSA_LEN_2 = 3'h2;
  localparam logic [2:0] RSA_LEN_3 = 3'h3;
  localparam logic [2:0] RSA_LEN_4 = 3'h4;

endpackage
`default_nettype wire

//--- test/rsa_addr_gen_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rsa_addr_gen_checker
  import rsa_pkg::*;
(
  input wire logic                    sys_clk,   // Clock
  input wire logic                    srst,      // Sync reset
  input wire logic                    start,     // Start pulse
  input wire rsa_pkg::rsa_instr_type  instr,     // Instruction fields
  input wire rsa_pkg::rsa_regs_type   regs,      // Register snapshot
  input wire logic                    ptr_valid, // Pointer data valid
  input wire logic [15:0]             ptr_data,  // Pointer data
  input wire logic                    ptr_req,   // Pointer read pending
  input wire logic [23:0]             ptr_addr,  // Pointer address
  input wire logic                    done,      // Result pulse
  input wire rsa_pkg::rsa_result_type result     // Result
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  wire logic        taken    = start && !ptr_req;
  wire logic        ptr_mode = instr.mode == RSA_MODE_STK_RIY || instr.mode == RSA_MODE_DIR_IY;
  wire logic        quick_go = taken && !ptr_mode;
  wire logic        ptr_back = ptr_req && ptr_valid;
  wire logic [15:0] rel_sum  = regs.pc_next + {{8{instr.byte2[7]}}, instr.byte2};
  wire logic [15:0] long_sum = regs.pc_next + {instr.byte3, instr.byte2};
  wire logic [15:0] stk_sum  = regs.sp + {8'h00, instr.byte2};
  wire logic [15:0] dir_sum  = regs.direct + {8'h00, instr.byte2};
  wire logic [15:0] ptr_low  = (instr.mode == RSA_MODE_STK_RIY) ? stk_sum : dir_sum;

  // Bank and Y as seen at the accepted start
  logic [7:0]  bank_reg;
  logic [15:0] y_reg;
  always_ff @(posedge sys_clk)
  begin
    if (taken)
    begin
      bank_reg <= regs.data_bank;
      y_reg    <= regs.y_idx;
    end
  end
  wire logic [23:0] riy_addr = {bank_reg, ptr_data} + {8'h00, y_reg};

  sequence accepted_s(rsa_mode_type m);
    taken && instr.mode == m;
  endsequence

  short_branch_a: assert property (accepted_s(RSA_MODE_REL) ##0 instr.cond_met
    |=> done && result.pc_load_en && result.pc_load == $past(rel_sum) && result.cycles == 4'h3)
    else $error("taken branch wrong");
  branch_skip_a: assert property (accepted_s(RSA_MODE_REL) ##0 !instr.cond_met
    |=> done && !result.pc_load_en && result.cycles == 4'h2)
    else $error("untaken branch wrong");
  long_branch_a: assert property (accepted_s(RSA_MODE_REL_LONG)
    ##0 instr.rl_op == RSA_RL_LONG_BRANCH |=> result.pc_load_en
    && result.pc_load == $past(long_sum) && result.cycles == 4'h4 && result.length == 3'h3)
    else $error("long branch wrong");
  push_relative_a: assert property (accepted_s(RSA_MODE_REL_LONG)
    ##0 instr.rl_op == RSA_RL_PUSH_RELATIVE |=> result.push_en && !result.pc_load_en
    && result.push_value == $past(long_sum) && result.addr[23:16] == RSA_BANK_ZERO)
    else $error("push relative wrong");
  stack_bank_a: assert property (accepted_s(RSA_MODE_STACK)
    |=> result.addr_valid && result.addr == {RSA_BANK_ZERO, $past(regs.sp)})
    else $error("stack bank not zero");
  stack_relative_a: assert property (accepted_s(RSA_MODE_STK_REL)
    |=> result.addr == {8'h00, $past(stk_sum)} && result.length == 3'h2)
    else $error("stack relative wrong");
  pointer_issue_a: assert property (taken && ptr_mode
    |=> ptr_req && !done && ptr_addr == {8'h00, $past(ptr_low)})
    else $error("pointer address wrong");
  pointer_hold_a: assert property (ptr_req && !ptr_valid |=> ptr_req && $stable(ptr_addr))
    else $error("pointer request dropped");
  pointer_result_a: assert property (ptr_back
    |=> done && !ptr_req && result.addr == $past(riy_addr) && result.length == 3'h2)
    else $error("indirect indexed wrong");
  stray_done_a: assert property (done |-> $past(quick_go) || $past(ptr_back))
    else $error("stray done");
endmodule // rsa_addr_gen_checker

bind rsa_addr_gen rsa_addr_gen_checker rsa_addr_gen_checker_inst (
  .sys_clk(sys_clk), .srst(srst), .start(start), .instr(instr), .regs(regs),
  .ptr_valid(ptr_valid), .ptr_data(ptr_data), .ptr_req(ptr_req), .ptr_addr(ptr_addr),
  .done(done), .result(result)
);
`default_nettype wire

//--- test/rsa_addr_gen_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rsa_addr_gen_tb;
  import rsa_pkg::*;
  localparam int CYCLE_LIMIT = 2000;
  logic           sys_clk;
  logic           srst;
  logic           start;
  rsa_instr_type  instr;
  rsa_regs_type   regs;
  logic           ptr_valid;
  logic [15:0]    ptr_data;
  logic           ptr_req;
  logic [23:0]    ptr_addr;
  logic           done;
  rsa_result_type result;
  logic [3:0]     wait_cycles;
  rsa_instr_type  i;
  rsa_regs_type   r;
  int             failures = 0;
  int             checked = 0;
  int             cycle_count = 0;

  rsa_addr_gen rsa_addr_gen_inst (
    .sys_clk(sys_clk), .srst(srst), .start(start), .instr(instr), .regs(regs),
    .ptr_valid(ptr_valid), .ptr_data(ptr_data), .ptr_req(ptr_req), .ptr_addr(ptr_addr),
    .done(done), .result(result)
  );
  rsa_ptr_mem rsa_ptr_mem_inst (
    .sys_clk(sys_clk), .srst(srst), .ptr_req(ptr_req), .ptr_addr(ptr_addr),
    .wait_cycles(wait_cycles), .ptr_valid(ptr_valid), .ptr_data(ptr_data)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycle_count++;
    if (cycle_count == CYCLE_LIMIT)
    begin
      failures = failures + 1;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    checked++;
    if (seen !== expected)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  localparam rsa_regs_type NARROW_REGS = '{program_bank: 8'hAB, data_bank: 8'hCD,
    sp: 16'h01F0, m_flag: 1'b1, x_flag: 1'b1, default: '0};

  task automatic issue();
    @(posedge sys_clk);
    start <= 1'b1;
    instr <= i;
    regs  <= r;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask

  task automatic run();
    issue();
    for (int n = 0; n < 20 && done !== 1'b1; n++)
      @(negedge sys_clk);
    check(32'(done), 32'h1);
  endtask

  task automatic fresh();
    i = '0;
    r = NARROW_REGS;
  endtask

  function automatic logic [23:0] br_view();
    return {result.pc_load, result.pc_load_en, result.cycles, result.length};
  endfunction

  function automatic logic [30:0] addr_view();
    return {result.addr, result.cycles, result.length};
  endfunction

  task automatic t_relative();
    fresh();
    r.pc_next = 16'h1000;
    i.mode = RSA_MODE_REL;
    i.cond_met = 1'b1;
    i.byte2 = 8'h80;
    run();
    check(br_view(), {16'h0F80, 1'b1, 4'h3, 3'h2});
    i.cond_met = 1'b0;
    run();
    check({result.pc_load_en, result.cycles}, {1'b0, 4'h2});
    i.cond_met = 1'b1;
    i.byte2 = 8'h7F;
    r.pc_next = 16'hFFF0;
    run();
    check(br_view(), {16'h006F, 1'b1, 4'h3, 3'h2});
    $display("relative done");
  endtask

  task automatic t_long();
    fresh();
    r.pc_next = 16'h1234;
    i.mode = RSA_MODE_REL_LONG;
    i.rl_op = RSA_RL_LONG_BRANCH;
    i.byte3 = 8'h80;
    run();
    check(br_view(), {16'h9234, 1'b1, 4'h4, 3'h3});
    i.rl_op = RSA_RL_PUSH_RELATIVE;
    i.byte3 = 8'h7F;
    i.byte2 = 8'hFF;
    r.pc_next = 16'h8001;
    run();
    check({result.push_en, result.pc_load_en, result.push_value}, 18'h20000);
    check(addr_view(), {8'h00, r.sp, 4'h3, 3'h3});
    $display("long relative done");
  endtask

  task automatic t_stack();
    fresh();
    i.mode = RSA_MODE_STACK;
    i.vector_fetch = 1'b1;
    r.data_bank = 8'hFF;
    r.sp = 16'hFFFE;
    run();
    check({result.addr_valid, result.addr}, {1'b1, 24'h00FFFE});
    i.mode = RSA_MODE_STK_REL;
    i.byte2 = 8'hFF;
    r.sp = 16'hFF80;
    run();
    check(addr_view(), {24'h00007F, 4'h4, 3'h2});
    i.wide_sensitive = 1'b1;
    r.m_flag = 1'b0;
    run();
    check(addr_view(), {24'h00007F, 4'h5, 3'h2});
    $display("stack done");
  endtask

  task automatic t_pointer();
    int extra;
    fresh();
    extra = 0;
    wait_cycles <= 4'h4;
    i.mode = RSA_MODE_STK_RIY;
    i.wide_sensitive = 1'b1;
    i.byte2 = 8'h20;
    r.data_bank = 8'h12;
    r.y_idx = 16'hFFFF;
    r.x_flag = 1'b0;
    rsa_ptr_mem_inst.load(32'h0210, 16'h8001);
    issue();
    @(negedge sys_clk);
    check({ptr_req, ptr_addr}, {1'b1, 24'h000210});
    i.mode = RSA_MODE_REL;
    run();
    check(addr_view(), {24'h138000, 4'h8, 3'h2});
    repeat (4)
    begin
      @(negedge sys_clk);
      extra += int'(done === 1'b1);
    end
    check(32'(extra), 32'h0);
    @(posedge sys_clk);
    wait_cycles <= 4'h0;
    fresh();
    i.mode = RSA_MODE_DIR_IY;
    i.byte2 = 8'h10;
    r.direct = 16'h0001;
    r.data_bank = 8'h00;
    r.y_idx = 16'h0020;
    rsa_ptr_mem_inst.load(32'h0011, 16'h12F0);
    run();
    check(addr_view(), {24'h001310, 4'h7, 3'h2});
    $display("pointer done");
  endtask

  task automatic cyc_case(input rsa_mode_type mode, input logic rmw, input logic m,
                          input logic [15:0] direct, input logic [15:0] x,
                          input logic [3:0] cyc, input logic [2:0] len);
    fresh();
    i.mode = mode;
    i.rmw = rmw;
    i.wide_sensitive = 1'b1;
    i.byte2 = 8'hFF;
    i.byte3 = 8'h10;
    r.m_flag = m;
    r.direct = direct;
    r.x_idx = x;
    run();
    check({result.cycles, result.length}, {cyc, len});
  endtask

  task automatic t_cycles();
    cyc_case(RSA_MODE_DIR_XI, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h7, 3'h2);
    cyc_case(RSA_MODE_DIR_LIY, 1'b0, 1'b1, 16'h0005, 16'h0000, 4'h7, 3'h2);
    cyc_case(RSA_MODE_ABS_IIJ, 1'b1, 1'b0, 16'h0001, 16'h0001, 4'h6, 3'h3);
    cyc_case(RSA_MODE_DIR, 1'b1, 1'b1, 16'h0100, 16'h0000, 4'h5, 3'h2);
    cyc_case(RSA_MODE_DIR, 1'b1, 1'b0, 16'h0001, 16'h0000, 4'h8, 3'h2);
    cyc_case(RSA_MODE_ABS_X, 1'b0, 1'b1, 16'h0000, 16'h0001, 4'h5, 3'h3);
    cyc_case(RSA_MODE_ABS_X, 1'b0, 1'b1, 16'h0000, 16'h0000, 4'h4, 3'h3);
    cyc_case(RSA_MODE_IMM, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h3, 3'h3);
    $display("cycles done");
  endtask

  initial
  begin
    srst = 1'b1;
    start = 1'b0;
    instr = '0;
    regs = '0;
    wait_cycles = 4'h0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_relative();
    t_long();
    t_stack();
    t_pointer();
    t_cycles();
    stop_test();
  end
endmodule // rsa_addr_gen_tb
`default_nettype wire

//--- test/rsa_ptr_mem.sv
`timescale 1ns/100ps
`default_nettype none
module rsa_ptr_mem
(
  input  wire logic        sys_clk,     // Clock
  input  wire logic        srst,        // Sync reset
  input  wire logic        ptr_req,     // Pointer read pending
  input  wire logic [23:0] ptr_addr,    // Pointer address
  input  wire logic [3:0]  wait_cycles, // Reply delay
  output logic             ptr_valid,   // Data valid pulse
  output logic [15:0]      ptr_data     // Pointer, low byte at ptr_addr
);
  logic [7:0] mem_bytes [int];
  logic [3:0] wait_reg;

  task automatic load(input int addr, input logic [15:0] value);
    mem_bytes[addr] = value[7:0];
    mem_bytes[addr + 1] = value[15:8];
  endtask

  initial
  begin
    ptr_valid = 1'b0;
    ptr_data = 16'h5A5A;
  end

  // Inverted outside replies so stale data never passes
  always @(posedge sys_clk)
  begin
    if (srst || !ptr_req || ptr_valid)
    begin
      ptr_valid <= 1'b0;
      ptr_data  <= ~ptr_data;
      wait_reg  <= 4'h0;
    end
    else if (wait_reg == wait_cycles)
    begin
      ptr_valid <= 1'b1;
      ptr_data  <= {mem_bytes[int'(ptr_addr) + 1], mem_bytes[int'(ptr_addr)]};
    end
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule // rsa_ptr_mem
`default_nettype wire
